// ===== rsm_engine.v
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "rsm_regs.vh"
module rsm_engine (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg master_select_n,
  output reg master_serial_clock,
  output reg master_serial_out,
  input wire master_serial_in,
  output reg [2:0] receiver_output_pin_levels,
  input wire tw_scl_i,
  output reg tw_scl_o,
  output reg tw_scl_oe,
  input wire tw_sda_i,
  output reg tw_sda_o,
  output reg tw_sda_oe,
  output reg xfer_ok_pulse
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam S_IDLE = 3'd0;
  localparam S_SPI_SEL = 3'd1;
  localparam S_SPI_HI = 3'd2;
  localparam S_SPI_LO = 3'd3;
  localparam S_SPI_END = 3'd4;
  localparam S_TW_START = 3'd5;
  localparam S_TW_BIT = 3'd6;
  localparam S_TW_STOP = 3'd7;

  reg [7:0] xbuf [0:15];
  reg [7:0] tx_buf [0:15];
  reg [7:0] cmd_reg, wcnt_reg, rcnt_reg, pins_reg, status_reg;
  reg run_spi_reg, run_stop_reg, fail_reg, fin_reg, ovr_reg, sel_lvl_reg;
  reg [9:0] run_div_reg, tick_reg;
  reg [4:0] run_wc_reg, run_rc_reg, idx_reg;
  reg [1:0] ph_reg, qtr_reg;
  reg [2:0] state_reg, sel_mask_reg;
  reg [3:0] bitc_reg;
  reg [8:0] sh_reg, rx_reg;
  reg miso_m, miso_s, sda_m, sda_s, scl_m, scl_s;
  reg nx_end, nx_rst;
  reg [1:0] nx_ph;
  reg [4:0] nx_idx;
  reg [8:0] nx_frame;
  reg [31:0] rd_val;
  integer i;

  // Address decode: 0 unmapped, 1 buffer, 2 command, 3 wcnt, 4 rcnt, 5 exec, 6 pins
  function [2:0] rsm_map;
    input [11:0] a;
    begin
      if (a[11:2] >= `RSM_IDX_BUF && a[11:2] <= `RSM_IDX_BUF_END)
        rsm_map = 3'd1;
      else if (a[11:2] == `RSM_IDX_CMD)
        rsm_map = 3'd2;
      else if (a[11:2] == `RSM_IDX_WCNT)
        rsm_map = 3'd3;
      else if (a[11:2] == `RSM_IDX_RCNT)
        rsm_map = 3'd4;
      else if (a[11:2] == `RSM_IDX_EXEC)
        rsm_map = 3'd5;
      else if (a[11:2] == `RSM_IDX_PINS)
        rsm_map = 3'd6;
      else
        rsm_map = 3'd0;
    end
  endfunction

  // Cycles per half bit (SPI) or quarter bit (2-wire)
  function [9:0] rsm_div;
    input spi;
    input [2:0] spd;
    integer t;
    begin
      case ({spi, spd})
        4'h8, 4'h9: t = `RSM_SPI_8M; // [RQ4]
        4'hA: t = `RSM_SPI_4M;
        4'hB: t = `RSM_SPI_2M;
        4'hC: t = `RSM_SPI_1M;
        4'hD: t = `RSM_SPI_500K;
        4'hE: t = `RSM_SPI_250K;
        4'h1: t = `RSM_TW_100K;
        4'h2: t = `RSM_TW_400K;
        4'h3: t = `RSM_TW_1M;
        default: t = 1;
      endcase
      rsm_div = t[9:0];
    end
  endfunction

  // Nine bit frame: data byte then acknowledge slot
  function [8:0] rsm_frame;
    input spi;
    input [1:0] ph;
    input last;
    input [7:0] b;
    begin
      case (ph)
        2'd0: rsm_frame = {b, 1'b1};
        2'd1: rsm_frame = {b[7:1], 2'b11};
        default: rsm_frame = spi ? 9'h001 : {8'hFF, last};
      endcase
    end
  endfunction

  wire [2:0] wmap = rsm_map(s_axi_awaddr);
  wire [2:0] rmap = rsm_map(s_axi_araddr);
  wire wr_take = s_axi_awready & s_axi_awvalid;
  wire wr_en = wr_take & s_axi_wstrb[0];
  wire [7:0] wb = s_axi_wdata[7:0];
  wire hit = (tick_reg == 10'h000);
  wire [2:0] cmd_spd = cmd_reg[3:1];
  wire cmd_spi = cmd_reg[`RSM_CMD_PROTO];
  wire [4:0] wc_cl = (wcnt_reg > `RSM_MAX_BYTES) ? 5'd16 : wcnt_reg[4:0]; // [RQ9]
  wire [4:0] rc_cl = (rcnt_reg > `RSM_MAX_BYTES) ? 5'd16 : rcnt_reg[4:0]; // [RQ10]
  wire go = wr_en && wmap == 3'd5 && wb == `RSM_EXEC_GO && state_reg == S_IDLE && !fin_reg;
  wire [9:0] go_div = rsm_div(cmd_spi, cmd_spd);
  wire [2:0] gpo_mix = (pins_reg[2:0] & ~sel_mask_reg) | (sel_mask_reg & {3{sel_lvl_reg}});
  wire [7:0] rd_byte = run_spi_reg ? rx_reg[7:0] : rx_reg[8:1];
  wire [1:0] sel_lo = cmd_reg[5:4];

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      miso_m <= 1'b0;
      miso_s <= 1'b0;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      scl_m <= 1'b1;
      scl_s <= 1'b1;
    end else begin
      miso_m <= master_serial_in;
      miso_s <= miso_m;
      sda_m <= tw_sda_i;
      sda_s <= sda_m;
      scl_m <= tw_scl_i;
      scl_s <= scl_m;
    end
  end

  // Next byte after the current one finishes
  always @* begin
    nx_end = 1'b0;
    nx_rst = 1'b0;
    nx_ph = ph_reg;
    nx_idx = idx_reg + 5'd1;
    case (ph_reg)
      2'd0: begin
        if (nx_idx >= run_wc_reg) begin
          if (run_rc_reg != 5'd0) begin // [RQ12]
            nx_ph = run_spi_reg ? 2'd2 : 2'd1;
            nx_idx = 5'd0;
            nx_rst = !run_spi_reg;
          end else begin
            nx_end = 1'b1;
          end
        end
      end
      2'd1: begin
        nx_ph = 2'd2;
        nx_idx = 5'd0;
      end
      default: nx_end = (nx_idx >= run_rc_reg);
    endcase
    nx_frame = rsm_frame(run_spi_reg, nx_ph, (nx_idx + 5'd1) >= run_rc_reg,
                         (nx_ph == 2'd0) ? tx_buf[nx_idx[3:0]] : tx_buf[0]);
  end

  // Read data mux
  always @* begin
    rd_val = 32'h00000000;
    case (rmap)
      3'd1: rd_val[7:0] = xbuf[s_axi_araddr[5:2]];
      3'd2: rd_val[7:0] = cmd_reg;
      3'd3: rd_val[7:0] = wcnt_reg;
      3'd4: rd_val[7:0] = rcnt_reg;
      3'd5: rd_val[7:0] = status_reg; // [RQ13]
      3'd6: rd_val[7:0] = pins_reg;
      default: rd_val = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // AXI4-Lite slave handshakes
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RSM_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RSM_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      // Address and data taken together once both are offered
      s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wmap == 3'd0) ? `RSM_RESP_SLVERR : `RSM_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arready & s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= (rmap == 3'd0) ? `RSM_RESP_SLVERR : `RSM_RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Registers and transfer engine
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 16; i = i + 1) begin
        xbuf[i] <= `RSM_ZERO_RST;
        tx_buf[i] <= `RSM_ZERO_RST;
      end
      cmd_reg <= `RSM_CMD_RST;
      wcnt_reg <= `RSM_ZERO_RST;
      rcnt_reg <= `RSM_ZERO_RST;
      pins_reg <= `RSM_ZERO_RST;
      status_reg <= `RSM_ST_OK;
      {run_spi_reg, run_stop_reg, fail_reg, fin_reg, ovr_reg, sel_lvl_reg} <= 6'h00;
      run_div_reg <= 10'h001;
      tick_reg <= 10'h000;
      {run_wc_reg, run_rc_reg, idx_reg} <= 15'h0000;
      {ph_reg, qtr_reg, bitc_reg} <= 8'h00;
      state_reg <= S_IDLE;
      sel_mask_reg <= 3'h0;
      sh_reg <= 9'h000;
      rx_reg <= 9'h000;
      master_select_n <= 1'b1;
      master_serial_clock <= 1'b0;
      master_serial_out <= 1'b0;
      receiver_output_pin_levels <= 3'h0;
      {tw_scl_o, tw_scl_oe, tw_sda_o, tw_sda_oe} <= 4'h0;
      xfer_ok_pulse <= 1'b0;
    end else begin
      xfer_ok_pulse <= 1'b0;
      receiver_output_pin_levels <= ovr_reg ? gpo_mix : pins_reg[2:0]; // [RQ2]
      if (tick_reg != 10'h000)
        tick_reg <= tick_reg - 10'h001;
      // Software writes, stored now; pins reach the output one cycle later, the rest are used only at execute
      if (wr_en) begin
        case (wmap)
          3'd1: xbuf[s_axi_awaddr[5:2]] <= wb; // [RQ11]
          3'd2: cmd_reg <= wb;
          3'd3: wcnt_reg <= wb;
          3'd4: rcnt_reg <= wb;
          3'd6: pins_reg <= wb;
          default: ;
        endcase
      end
      // Close of a command
      if (fin_reg) begin
        fin_reg <= 1'b0;
        ovr_reg <= 1'b0;
        sel_mask_reg <= 3'h0;
        status_reg <= fail_reg ? `RSM_ST_FAIL : `RSM_ST_OK; // [RQ13]
        xfer_ok_pulse <= !fail_reg; // [RQ15]
      end
      case (state_reg)
        S_IDLE: begin
          if (go) begin
            // Snapshot of settings, counts and buffer [RQ8] [RQ16]
            status_reg <= `RSM_ST_BUSY;
            run_spi_reg <= cmd_spi;
            run_stop_reg <= (cmd_reg[6:4] != `RSM_TW_NOSTOP); // [RQ3]
            run_div_reg <= go_div;
            tick_reg <= go_div - 10'h001;
            run_wc_reg <= wc_cl;
            run_rc_reg <= rc_cl;
            for (i = 0; i < 16; i = i + 1)
              tx_buf[i] <= xbuf[i];
            idx_reg <= 5'd0;
            bitc_reg <= 4'd0;
            qtr_reg <= 2'd0;
            fail_reg <= 1'b0;
            fin_reg <= 1'b1;
            if (cmd_spd == `RSM_SPD_NONE || (wc_cl == 5'd0 && rc_cl == 5'd0)) begin
              fail_reg <= 1'b0; // [RQ6]
            end else if (!cmd_spi && (cmd_spd == 3'h0 || cmd_spd > 3'h3)) begin
              fail_reg <= 1'b1;
            end else if (cmd_spi) begin // [RQ1]
              fin_reg <= 1'b0;
              ph_reg <= (wc_cl != 5'd0) ? 2'd0 : 2'd2;
              sh_reg <= rsm_frame(1'b1, (wc_cl != 5'd0) ? 2'd0 : 2'd2, 1'b0, xbuf[0]);
              master_serial_out <= (wc_cl != 5'd0) ? xbuf[0][7] : 1'b0;
              if (sel_lo == 2'd0) begin
                master_select_n <= 1'b0; // [RQ20]
              end else begin
                ovr_reg <= 1'b1;
                tick_reg <= go_div; // Output pin selects a cycle late, keep a full half bit [RQ17]
                sel_mask_reg <= 3'h1 << (sel_lo - 2'd1); // [RQ2]
                sel_lvl_reg <= cmd_reg[6];
              end
              state_reg <= S_SPI_SEL;
            end else begin
              fin_reg <= 1'b0;
              ph_reg <= (wc_cl != 5'd0) ? 2'd0 : 2'd1;
              sh_reg <= rsm_frame(1'b0, (wc_cl != 5'd0) ? 2'd0 : 2'd1, 1'b0, xbuf[0]);
              state_reg <= S_TW_START;
            end
          end
        end
        S_SPI_SEL, S_SPI_LO: begin
          if (hit) begin
            // Rising edge: sample incoming bit [RQ17] [RQ18]
            tick_reg <= run_div_reg - 10'h001;
            master_serial_clock <= 1'b1;
            rx_reg <= {rx_reg[7:0], miso_s};
            bitc_reg <= bitc_reg + 4'd1;
            state_reg <= S_SPI_HI;
          end
        end
        S_SPI_HI: begin
          if (hit) begin
            // Falling edge: present next bit [RQ18]
            tick_reg <= run_div_reg - 10'h001;
            master_serial_clock <= 1'b0;
            state_reg <= S_SPI_LO;
            if (bitc_reg == 4'd8) begin
              bitc_reg <= 4'd0;
              if (ph_reg == 2'd2)
                xbuf[idx_reg[3:0]] <= rd_byte; // [RQ12]
              ph_reg <= nx_ph;
              idx_reg <= nx_idx;
              sh_reg <= nx_frame;
              master_serial_out <= nx_frame[8];
              if (nx_end)
                state_reg <= S_SPI_END;
            end else begin
              sh_reg <= {sh_reg[7:0], 1'b1};
              master_serial_out <= sh_reg[7];
            end
          end
        end
        S_SPI_END: begin
          if (hit) begin
            master_select_n <= 1'b1;
            master_serial_out <= 1'b0;
            fin_reg <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        S_TW_START, S_TW_STOP: begin
          if (hit) begin
            tick_reg <= run_div_reg - 10'h001;
            qtr_reg <= qtr_reg + 2'd1;
            case (qtr_reg)
              2'd0: tw_sda_oe <= (state_reg == S_TW_STOP);
              2'd1: tw_scl_oe <= 1'b0;
              2'd2: begin
                if (!scl_s)
                  qtr_reg <= qtr_reg; // Slave holds the clock low
                else
                  tw_sda_oe <= (state_reg == S_TW_START);
              end
              default: begin
                if (state_reg == S_TW_START) begin
                  tw_scl_oe <= 1'b1;
                  bitc_reg <= 4'd0;
                  state_reg <= S_TW_BIT;
                end else begin
                  fin_reg <= 1'b1;
                  state_reg <= S_IDLE;
                end
              end
            endcase
          end
        end
        S_TW_BIT: begin
          if (hit) begin
            tick_reg <= run_div_reg - 10'h001;
            qtr_reg <= qtr_reg + 2'd1;
            case (qtr_reg)
              2'd0: tw_sda_oe <= ~sh_reg[8];
              2'd1: tw_scl_oe <= 1'b0;
              2'd2: begin
                if (!scl_s)
                  qtr_reg <= qtr_reg;
                else
                  rx_reg <= {rx_reg[7:0], sda_s};
              end
              default: begin
                tw_scl_oe <= 1'b1;
                sh_reg <= {sh_reg[7:0], 1'b1};
                bitc_reg <= bitc_reg + 4'd1;
                if (bitc_reg == 4'd8) begin
                  bitc_reg <= 4'd0;
                  tw_sda_oe <= 1'b0;
                  if (ph_reg == 2'd2)
                    xbuf[idx_reg[3:0]] <= rd_byte;
                  if ((ph_reg != 2'd2 && rx_reg[0]) || nx_end) begin
                    fail_reg <= (ph_reg != 2'd2 && rx_reg[0]); // [RQ21]
                    if (run_stop_reg) begin
                      state_reg <= S_TW_STOP; // [RQ3]
                    end else begin
                      fin_reg <= 1'b1;
                      state_reg <= S_IDLE;
                    end
                  end else begin
                    ph_reg <= nx_ph;
                    idx_reg <= nx_idx;
                    sh_reg <= nx_frame;
                    if (nx_rst)
                      state_reg <= S_TW_START;
                  end
                end
              end
            endcase
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

// ===== rsm_engine_bench.sv
`timescale 1ns/1ps
`include "rsm_regs.vh"
module rsm_engine_bench;
  typedef struct {logic [7:0] cmd; logic [7:0] wc; logic [7:0] rc; int half; logic [7:0] st;} rsm_row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, gsel, ghi;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rdv;
  logic [1:0] resp, gidx;
  logic [2:0] s;
  logic [7:0] reply, pv;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire master_select_n, master_serial_clock, master_serial_out, master_serial_in;
  wire tw_scl_oe, tw_sda_oe, tw_scl_o, tw_sda_o, xfer_ok_pulse, peer_sel_n;
  wire tw_scl_i = !tw_scl_oe;
  wire tw_sda_i = !tw_sda_oe;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [2:0] receiver_output_pin_levels;
  wire [127:0] rx_log;
  int rx_count, errors, samples_checked, pulses, hi_cnt, hi_len, dsel_low, c0, p0, n;
  rsm_row_t rows [11] = '{
    '{8'h82, 8'h10, 8'h00, 16, 8'h00}, '{8'h90, 8'h00, 8'h10, 16, 8'h00}, '{8'hE4, 8'h01, 8'h00, 32, 8'h00},
    '{8'hB6, 8'h01, 8'h01, 63, 8'h00}, '{8'hC8, 8'h01, 8'h00, 125, 8'h00}, '{8'hDA, 8'h01, 8'h00, 250, 8'h00},
    '{8'hFC, 8'h01, 8'h00, 500, 8'h00}, '{8'h8E, 8'h02, 8'h02, 0, 8'h00}, '{8'h00, 8'h01, 8'h00, 0, 8'h02},
    '{8'h04, 8'h01, 8'h00, 0, 8'h02}, '{8'h16, 8'h01, 8'h00, 0, 8'h02}};
  logic [9:0] rst_idx [7] = '{`RSM_IDX_CMD, `RSM_IDX_WCNT, `RSM_IDX_RCNT, `RSM_IDX_EXEC, 10'h065, `RSM_IDX_PINS, 10'h07F};
  logic [7:0] rst_val [7] = '{8'h82, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  rsm_engine rsm_engine_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .master_select_n,
    .master_serial_clock, .master_serial_out, .master_serial_in, .receiver_output_pin_levels, .tw_scl_i,
    .tw_scl_o, .tw_scl_oe, .tw_sda_i, .tw_sda_o, .tw_sda_oe, .xfer_ok_pulse);
  rsm_spi_peer rsm_spi_peer_i (.sel_n(peer_sel_n), .sck(master_serial_clock), .mosi(master_serial_out),
    .reply(reply), .miso(master_serial_in), .rx_log(rx_log), .rx_count(rx_count));
  // Peer select follows the chosen pin and polarity
  assign peer_sel_n = gsel ? receiver_output_pin_levels[gidx] ^ ghi : master_select_n;
  // ------------------------------
  // Clock, monitor and checking tasks
  // ------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Clock-high length, dedicated select use, completion pulses
  always @(posedge aclk) begin
    if (master_serial_clock) hi_cnt <= hi_cnt + 1;
    else if (hi_cnt != 0) begin
      hi_len <= hi_cnt;
      hi_cnt <= 0;
    end
    if (!master_select_n) dsel_low <= 1;
    if (xfer_ok_pulse) pulses <= pulses + 1;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    bit aw, w;
    int k;
    aw = 1;
    w = 1;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while ((aw || w) && k < 100) begin
      @(posedge aclk);
      k++;
      if (aw && s_axi_awready) begin s_axi_awvalid <= 1'b0; aw = 0; end
      if (w && s_axi_wready) begin s_axi_wvalid <= 1'b0; w = 0; end
    end
    do begin @(posedge aclk); k++; end while (!s_axi_bvalid && k < 100);
    // Late ready makes the slave hold its answer for a cycle
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k >= 100) chk(k, 0);
  endtask
  task automatic rd(input logic [9:0] idx);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do begin @(posedge aclk); k++; end while (!s_axi_arready && k < 100);
    s_axi_arvalid <= 1'b0;
    do begin @(posedge aclk); k++; end while (!s_axi_rvalid && k < 100);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    rdv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k >= 100) chk(k, 0);
  endtask
  task automatic run_exec();
    int k;
    k = 0;
    wr(`RSM_IDX_EXEC, `RSM_EXEC_GO);
    do begin rd(`RSM_IDX_EXEC); k++; end while (rdv === 32'h1 && k < 20000);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    complete_run();
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, gsel, ghi} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, gidx, reply} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 11; k++) begin
      s = rows[k].cmd[6:4];
      gsel = rows[k].cmd[7] && s != 3'h0 && s != 3'h4;
      gidx = s[1:0] - 2'h1;
      ghi = s[2];
      pv = (gsel && !ghi) ? 8'h01 << gidx : 8'h00;
      reply = 8'h30 + 8'(k);
      wr(`RSM_IDX_PINS, pv);
      for (int j = 0; j < rows[k].wc; j++) wr(`RSM_IDX_BUF + j, 8'hA0 + 8'(j + k));
      wr(`RSM_IDX_CMD, rows[k].cmd);
      wr(`RSM_IDX_WCNT, rows[k].wc);
      wr(`RSM_IDX_RCNT, rows[k].rc);
      c0 = rx_count;
      p0 = pulses;
      hi_len = 0;
      dsel_low = 0;
      run_exec();
      chk(rdv, rows[k].st);
      n = (rows[k].cmd[7] && rows[k].half != 0) ? rows[k].wc + rows[k].rc : 0;
      chk(rx_count - c0, n);
      for (int j = 0; j < rows[k].wc && n != 0; j++) chk(rx_log[8 * (n - 1 - j) +: 8], 8'hA0 + 8'(j + k));
      for (int j = 0; j < rows[k].rc && n != 0; j++) begin
        rd(`RSM_IDX_BUF + j);
        chk(rdv, reply + rows[k].wc + 8'(j));
      end
      chk(hi_len, rows[k].half);
      chk(dsel_low, !gsel && n != 0);
      chk(receiver_output_pin_levels, pv);
      chk(pulses - p0, rows[k].st == 8'h00);
      if (!rows[k].cmd[7]) chk({tw_scl_oe, tw_sda_oe, tw_scl_o, tw_sda_o}, rows[k].cmd[4] ? 4'h8 : 4'h0);
      $display("row %0d done", k);
    end
    // Later register changes must not reach a running transfer
    gsel = 1'b0;
    wr(`RSM_IDX_BUF, 8'hA5);
    wr(`RSM_IDX_WCNT, 8'h01);
    wr(`RSM_IDX_RCNT, 8'h00);
    wr(`RSM_IDX_CMD, 8'hC8);
    c0 = rx_count;
    wr(`RSM_IDX_EXEC, `RSM_EXEC_GO);
    rd(`RSM_IDX_EXEC);
    chk(rdv, `RSM_ST_BUSY);
    wr(`RSM_IDX_BUF, 8'h5A);
    wr(`RSM_IDX_WCNT, 8'h03);
    wr(`RSM_IDX_CMD, 8'h8E);
    run_exec();
    chk(rdv, `RSM_ST_OK);
    chk(rx_count - c0, 1);
    chk(rx_log[7:0], 8'hA5);
    chk(hi_len, 125);
    wr(10'h07F, 8'h01);
    chk(resp, `RSM_RESP_SLVERR);
    $display("frozen settings test done");
    // Reset during a running transfer restores reset values; last entry is unmapped
    wr(`RSM_IDX_CMD, 8'hFC);
    wr(`RSM_IDX_EXEC, `RSM_EXEC_GO);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int j = 0; j < 7; j++) begin
      rd(rst_idx[j]);
      chk(rdv, rst_val[j]);
      chk(resp, j == 6 ? `RSM_RESP_SLVERR : `RSM_RESP_OKAY);
    end
    chk({master_select_n, receiver_output_pin_levels}, 4'h8);
    $display("reset test done");
    complete_run();
  end
endmodule

// ===== rsm_engine_sva.sv
`timescale 1ns/1ps
module rsm_engine_sva (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire master_select_n,
  input wire master_serial_clock,
  input wire master_serial_out,
  input wire xfer_ok_pulse
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------
  // Register bus handshakes
  // ------------------------------
  a_wr_answer_next:
    assert property (s_axi_awready |=> s_axi_bvalid) else $error("write answer not one cycle after take");
  a_wr_taken_together:
    assert property (s_axi_awready |-> s_axi_wready) else $error("address and data taken apart");
  a_b_held:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_rd_answer_next:
    assert property (s_axi_arready |=> s_axi_rvalid) else $error("read answer not one cycle after take");
  a_r_held:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  // ------------------------------
  // Serial pins and completion
  // ------------------------------
  a_sel_lead_gap:
    assert property ($fell(master_select_n) |-> !master_serial_clock [*8]) else $error("clock too soon after select");
  a_data_on_fall:
    assert property ($changed(master_serial_out) |-> !master_serial_clock) else $error("data moved while clock high");
  a_pulse_single:
    assert property (xfer_ok_pulse |=> !xfer_ok_pulse) else $error("completion pulse too long");
  cover property ($fell(master_select_n));
  cover property (xfer_ok_pulse);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind rsm_engine rsm_engine_sva rsm_engine_sva_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .master_select_n(master_select_n), .master_serial_clock(master_serial_clock),
  .master_serial_out(master_serial_out), .xfer_ok_pulse(xfer_ok_pulse));

// ===== rsm_regs.vh
// Notes on behaviour
// (RQ1) Command bit 7 selects SPI or 2-wire
// (RQ2) SPI select field picks pin and polarity
// (RQ3) 2-wire code 001 omits the stop
// (RQ4) SPI speed code sets bit rate
// (RQ5) Software uses only legal 2-wire speeds
// (RQ6) Speed code 111 keeps pins quiet
// (RQ7) Software writes zero to command bit 0
// (RQ8) Command settings sampled at execute write
// (RQ9) Write count up to 16 bytes
// (RQ10) Read count up to 16 bytes
// (RQ11) Sixteen byte buffer sends and receives
// (RQ12) Write phase first, then read phase
// (RQ13) Execute reads 0 ok, 1 busy, 2 fail
// (RQ14) Software writes 1 then polls idle
// (RQ15) Successful command may raise notice pulse
// (RQ16) Counts and buffer sampled at execute write
// (RQ17) First clock half period after select
// (RQ18) Data changes on fall, sampled on rise
// (RQ19) Software presets output pin inactive level
// (RQ20) Dedicated select always active low
// (RQ21) Missing 2-wire acknowledge ends as failure
`ifndef RSM_REGS_VH
`define RSM_REGS_VH
// ----------------------------------------
// Register indexes, byte address is four times index
// ----------------------------------------
`define RSM_IDX_BUF 10'h060
`define RSM_IDX_BUF_END 10'h06F
`define RSM_IDX_CMD 10'h070
`define RSM_IDX_WCNT 10'h071
`define RSM_IDX_RCNT 10'h072
`define RSM_IDX_EXEC 10'h074
`define RSM_IDX_PINS 10'h076
// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define RSM_CMD_RST 8'h82
`define RSM_ZERO_RST 8'h00
`define RSM_CMD_PROTO 7
`define RSM_SPD_NONE 3'h7
`define RSM_TW_NOSTOP 3'h1
`define RSM_EXEC_GO 8'h01
`define RSM_ST_OK 8'h00
`define RSM_ST_BUSY 8'h01
`define RSM_ST_FAIL 8'h02
`define RSM_MAX_BYTES 8'h10
`define RSM_RESP_OKAY 2'h0
`define RSM_RESP_SLVERR 2'h2
// ----------------------------------------
// Timing: clock in kHz, rates in kbit/s
// ----------------------------------------
`define RSM_CLK_KHZ 250000
`define RSM_HALF(k) ((`RSM_CLK_KHZ + 2 * (k) - 1) / (2 * (k)))
`define RSM_QTR(k) ((`RSM_CLK_KHZ + 4 * (k) - 1) / (4 * (k)))
`define RSM_SPI_8M `RSM_HALF(8000)
`define RSM_SPI_4M `RSM_HALF(4000)
`define RSM_SPI_2M `RSM_HALF(2000)
`define RSM_SPI_1M `RSM_HALF(1000)
`define RSM_SPI_500K `RSM_HALF(500)
`define RSM_SPI_250K `RSM_HALF(250)
`define RSM_TW_100K `RSM_QTR(100)
`define RSM_TW_400K `RSM_QTR(400)
`define RSM_TW_1M `RSM_QTR(1000)
`endif

// ===== rsm_spi_peer.sv
`timescale 1ns/1ps
module rsm_spi_peer (
  input wire sel_n,
  input wire sck,
  input wire mosi,
  input wire [7:0] reply,
  output logic miso,
  output logic [127:0] rx_log,
  output int rx_count
);
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  int nbit;
  initial begin
    miso = 1'b0;
    rx_log = '0;
    rx_count = 0;
    nbit = 0;
  end
  // First reply bit ready once selected
  always @(negedge sel_n) begin
    nbit = 0;
    tx_sh = reply;
    miso = reply[7];
  end
  // Capture on the rising clock, log whole bytes
  always @(posedge sck) if (!sel_n) begin
    rx_sh = {rx_sh[6:0], mosi};
    nbit++;
    if (nbit % 8 == 0) begin
      rx_log = {rx_log[119:0], rx_sh};
      rx_count++;
    end
  end
  // Next bit after the falling clock; byte n replies reply plus n
  always @(negedge sck) if (!sel_n) begin
    tx_sh = (nbit % 8 == 0) ? reply + 8'(nbit / 8) : {tx_sh[6:0], 1'b0};
    miso = tx_sh[7];
  end
  // Released line never keeps the last bit
  always @(posedge sel_n) miso = ~miso;
endmodule
